// ### rtl/trc_map.vh
`ifndef TRC_MAP_VH
`define TRC_MAP_VH

// Register offsets on the serial control bus.
`define TRC_OFS_MIXER   7'h18
`define TRC_OFS_AGC     7'h19
`define TRC_OFS_AMOSC   7'h1a
`define TRC_OFS_HOLE    7'h1b
`define TRC_OFS_STEREO  7'h1c
`define TRC_OFS_STAUX   7'h1d
`define TRC_OFS_BLEND   7'h1e
`define TRC_OFS_BAND    7'h1f
`define TRC_OFS_BASE    7'h18

// Reset values of the bank, in offset order.
`define TRC_RST_MIXER   8'h20
`define TRC_RST_AGC     8'h41
`define TRC_RST_AMOSC   8'h00
`define TRC_RST_STEREO  8'h60
`define TRC_RST_STAUX   8'h00
`define TRC_RST_BLEND   8'h00
`define TRC_RST_BAND    8'h00

// Field positions: single bits by number, multi-bit fields by their low bit.
`define TRC_B_IQSWAP    7
`define TRC_B_IFSIGN    6
`define TRC_F_OSCLEV    4
`define TRC_B_DEEMPH    3
`define TRC_F_VOLUME    1
`define TRC_B_AMHC      0
`define TRC_B_AMMUTE    5
`define TRC_B_IFSPD     3
`define TRC_F_RFSPD     1
`define TRC_B_RFLOOP    0
`define TRC_F_AMGAIN    5
`define TRC_F_AMDET     2
`define TRC_F_AMSPD     0
`define TRC_F_CAPT      6
`define TRC_B_STFAST    5
`define TRC_B_STSLOW    4
`define TRC_B_PILOT     2
`define TRC_B_FSTEREO   1
`define TRC_B_STMONO    0
`define TRC_B_FGAIN     4
`define TRC_F_SEP       0
`define TRC_F_SBLEND    5
`define TRC_F_SMUTE     2
`define TRC_B_DCSHIFT   1
`define TRC_B_FBLEND_N  0
`define TRC_B_RANGE     7
`define TRC_B_IFLIM     6
`define TRC_B_IFSPD_N   5
`define TRC_B_BAND      4
`define TRC_B_AMP       3
`define TRC_B_UNMUTE    2
`define TRC_B_AMCAL     1
`define TRC_B_PWR       0

// Serial frame layout: read flag in the top bit of the address byte.
`define TRC_B_RDFLAG    7
`define TRC_BITS_LAST   4'h7

`endif

// ### rtl/trc_serial_port.v
`timescale 1ns/1ps
`default_nettype none

module trc_serial_port
(
    input  wire       ref_clk_i,
    input  wire       srst_i,
    input  wire       ce_i,
    input  wire       chip_enable_i,
    input  wire       serial_clock_i,
    input  wire       serial_in_i,
    input  wire [7:0] rd_data_i,
    output reg  [6:0] addr_o,
    output reg        wr_stb_o,
    output reg  [7:0] wr_data_o,
    output reg        serial_out_oe_o
);

`include "trc_map.vh"

reg        sclk_q;
reg  [3:0] bit_cnt;
reg  [7:0] shreg;
reg  [7:0] tx;
reg        have_addr;
reg        rd_mode;
reg        tx_first;
wire       sclk_rise = serial_clock_i & ~sclk_q;
wire       sclk_fall = ~serial_clock_i & sclk_q;
wire [7:0] next_shreg = {serial_in_i, shreg[7:1]};

////////////////////////////////////////////////////////////////////////////////
// Bits arrive LSB first on rising clock edges; the address byte comes first.
// Read data leaves on falling edges so the host can sample on the next rise.
always @(posedge ref_clk_i)
begin
    if (srst_i)
    begin
        sclk_q          <= 1'b0;
        bit_cnt         <= 4'h0;
        shreg           <= 8'h00;
        tx              <= 8'h00;
        have_addr       <= 1'b0;
        rd_mode         <= 1'b0;
        tx_first        <= 1'b0;
        addr_o          <= 7'h00;
        wr_stb_o        <= 1'b0;
        wr_data_o       <= 8'h00;
        serial_out_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
        sclk_q   <= serial_clock_i;
        wr_stb_o <= 1'b0;
        if (!chip_enable_i)
        begin
            // A dropped enable abandons any partial byte and frees the pin.
            bit_cnt         <= 4'h0;
            have_addr       <= 1'b0;
            rd_mode         <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end
        else if (sclk_rise && !(have_addr && rd_mode))
        begin
            shreg <= next_shreg;
            if (bit_cnt == `TRC_BITS_LAST)
            begin
                bit_cnt <= 4'h0;
                if (!have_addr)
                begin
                    addr_o    <= next_shreg[6:0];
                    rd_mode   <= next_shreg[`TRC_B_RDFLAG];
                    have_addr <= 1'b1;
                    tx_first  <= 1'b1;
                end
                else
                begin
                    wr_stb_o  <= 1'b1;
                    wr_data_o <= next_shreg;
                end
            end
            else
            begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
        else if (sclk_fall && have_addr && rd_mode)
        begin
            // Open drain: the pin is pulled low only for a zero bit.
            if (tx_first || bit_cnt == 4'h0)
            begin
                serial_out_oe_o <= ~rd_data_i[0];
                tx              <= {1'b0, rd_data_i[7:1]};
            end
            else
            begin
                serial_out_oe_o <= ~tx[0];
                tx              <= {1'b0, tx[7:1]};
            end
            tx_first <= 1'b0;
            bit_cnt  <= (bit_cnt == `TRC_BITS_LAST) ? 4'h0 : bit_cnt + 4'h1;
        end
    end
end

endmodule
`default_nettype wire

// ### rtl/trc_radio_ctrl.v
// How it works
// - Bit 7 of mixer register swaps I/Q phase.
// - Bit 6 of mixer register subtracts IF.
// - Two-bit oscillator level, zero minimum, three maximum.
// - De-emphasis bit picks 50 or 75 microseconds.
// - Bit 5 of gain register enables AM mute.
// - Bit 3 of gain register picks fast IF gain.
// - Bit 0 of gain register enables RF gain loop.
// - Antenna gain and detect level, three bits each.
// - Low two bits set AM gain loop speed.
// - Top two stereo bits set capture range.
// - Stereo bits 5 and 4 enable fast, slow sensing.
// - Stereo bit 2 enables pilot cancellation.
// - Stereo bit 1 forces stereo mode.
// - Aux bit 4 forces the gain loop on.
// - Aux low two bits trim channel separation.
// - Three-bit soft blend level, zero disables it.
// - Three-bit soft mute level, zero disables it.
// - Blend bit 1 shifts the audio DC level.
// - Blend bit 0 low forces soft blend on.
// - Band bit 7 selects the eastern band range.
// - Band bit 6 caps the IF oscillator.
`timescale 1ns/1ps
`default_nettype none

module trc_radio_ctrl
(
    input  wire       ref_clk_i,
    input  wire       srst_i,
    input  wire       ce_i,
    input  wire       chip_enable_i,
    input  wire       serial_clock_i,
    input  wire       serial_in_i,
    output wire       serial_out_o,
    output wire       serial_out_oe_o,
    output wire       iq_phase_swap_o,
    output wire       if_sign_select_o,
    output wire [1:0] rf_osc_level_o,
    output wire       deemphasis_select_o,
    output wire [1:0] volume_level_o,
    output wire       am_highcut_enable_o,
    output wire       am_mute_enable_o,
    output wire       if_gain_speed_o,
    output wire [1:0] rf_gain_speed_o,
    output wire       rf_gain_loop_enable_o,
    output wire [2:0] am_antenna_gain_o,
    output wire [2:0] am_detect_level_o,
    output wire [1:0] am_gain_loop_speed_o,
    output wire [1:0] capture_range_o,
    output wire       stereo_fast_sense_o,
    output wire       stereo_slow_sense_o,
    output wire       pilot_cancel_enable_o,
    output wire       forced_stereo_o,
    output wire       stereo_mono_select_o,
    output wire       forced_gain_loop_o,
    output wire [1:0] separation_trim_o,
    output wire [2:0] soft_blend_level_o,
    output wire [2:0] soft_mute_level_o,
    output wire       audio_dc_shift_o,
    output wire       forced_soft_blend_n_o,
    output wire       band_range_select_o,
    output wire       if_osc_limit_o,
    output wire       if_gain_speed_n_o,
    output wire       band_select_o,
    output wire       audio_amp_enable_o,
    output wire       audio_mute_n_o,
    output wire       am_antenna_cal_o,
    output wire       radio_power_o,
    output reg        power_save_o
);

`include "trc_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Serial front end.

wire [6:0] addr;
wire       wr_stb;
wire [7:0] wr_data;
reg  [7:0] rd_data;

// The open-drain data pin only ever pulls low; its level is always zero.
assign serial_out_o = 1'b0;

trc_serial_port u_port
(
    .ref_clk_i       (ref_clk_i),
    .srst_i          (srst_i),
    .ce_i            (ce_i),
    .chip_enable_i   (chip_enable_i),
    .serial_clock_i  (serial_clock_i),
    .serial_in_i     (serial_in_i),
    .rd_data_i       (rd_data),
    .addr_o          (addr),
    .wr_stb_o        (wr_stb),
    .wr_data_o       (wr_data),
    .serial_out_oe_o (serial_out_oe_o)
);

////////////////////////////////////////////////////////////////////////////////
// Register bank: eight flip-flop bytes indexed by offset minus the base.

reg  [7:0] bank [0:7];
wire [6:0] rel  = addr - `TRC_OFS_BASE;
wire       hit  = (rel[6:3] == 4'h0) && (addr != `TRC_OFS_HOLE); // Offsets below the base wrap high.
wire [2:0] idx  = rel[2:0];

// Reset image per entry; the hole at index 3 is never written.
function [7:0] rst_val;
    input integer i;
    begin
        case (i)
            3'h0:    rst_val = `TRC_RST_MIXER;
            3'h1:    rst_val = `TRC_RST_AGC;
            3'h2:    rst_val = `TRC_RST_AMOSC;
            3'h4:    rst_val = `TRC_RST_STEREO;
            3'h5:    rst_val = `TRC_RST_STAUX;
            3'h6:    rst_val = `TRC_RST_BLEND;
            3'h7:    rst_val = `TRC_RST_BAND;
            default: rst_val = 8'h00;
        endcase
    end
endfunction

// Each entry keeps every bit the host wrote, reserved ones included,
// so a read-back shows exactly what software set.
genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_bank
        always @(posedge ref_clk_i)
        begin
            if (srst_i)
            begin
                bank[g] <= rst_val(g);
            end
            else if (ce_i && wr_stb && hit && idx == g)
            begin
                bank[g] <= wr_data;
            end
        end
    end
endgenerate

// Read mux; unmapped offsets and the hole return zero.
always @*
begin
    rd_data = 8'h00;
    if (hit)
    begin
        rd_data = bank[idx];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mixer and audio settings.

// Upper heterodyne when clear, image countermeasure when set.
assign iq_phase_swap_o     = bank[0][`TRC_B_IQSWAP];
// The tuning sequencer adds the IF when clear and subtracts when set.
assign if_sign_select_o    = bank[0][`TRC_B_IFSIGN];
// Steps of roughly 3 dB; the reset image lands on the usual level two.
assign rf_osc_level_o      = bank[0][`TRC_F_OSCLEV +: 2];
// Clear picks 50 us, set picks 75 us.
assign deemphasis_select_o = bank[0][`TRC_B_DEEMPH];
assign volume_level_o      = bank[0][`TRC_F_VOLUME +: 2];
assign am_highcut_enable_o = bank[0][`TRC_B_AMHC];

////////////////////////////////////////////////////////////////////////////////
// Gain loop and mute settings.

assign am_mute_enable_o      = bank[1][`TRC_B_AMMUTE];
// Clear is the slow loop, set the fast one.
assign if_gain_speed_o       = bank[1][`TRC_B_IFSPD];
assign rf_gain_speed_o       = bank[1][`TRC_F_RFSPD +: 2];
// Normal operation keeps this set; the reset image does so.
assign rf_gain_loop_enable_o = bank[1][`TRC_B_RFLOOP];

////////////////////////////////////////////////////////////////////////////////
// AM antenna oscillator settings.

assign am_antenna_gain_o    = bank[2][`TRC_F_AMGAIN +: 3];
assign am_detect_level_o    = bank[2][`TRC_F_AMDET +: 3];
// Zero is the slowest loop, three the fastest.
assign am_gain_loop_speed_o = bank[2][`TRC_F_AMSPD +: 2];

////////////////////////////////////////////////////////////////////////////////
// Stereo decoder settings.

// Zero narrow, one usual, three wide.
assign capture_range_o       = bank[4][`TRC_F_CAPT +: 2];
// The two speeds are independent enables, not a coded field.
assign stereo_fast_sense_o   = bank[4][`TRC_B_STFAST];
assign stereo_slow_sense_o   = bank[4][`TRC_B_STSLOW];
assign pilot_cancel_enable_o = bank[4][`TRC_B_PILOT];
// Clear leaves the stereo or mono decision to the decoder.
assign forced_stereo_o       = bank[4][`TRC_B_FSTEREO];
assign stereo_mono_select_o  = bank[4][`TRC_B_STMONO];

////////////////////////////////////////////////////////////////////////////////
// Stereo auxiliary settings.

assign forced_gain_loop_o = bank[5][`TRC_B_FGAIN];
// Subcarrier level, minimum at zero.
assign separation_trim_o  = bank[5][`TRC_F_SEP +: 2];

////////////////////////////////////////////////////////////////////////////////
// Soft blend and soft mute settings.

// Zero turns each function off; seven is the strongest level.
assign soft_blend_level_o    = bank[6][`TRC_F_SBLEND +: 3];
assign soft_mute_level_o     = bank[6][`TRC_F_SMUTE +: 3];
// Clear suits the low supply, set the high supply.
assign audio_dc_shift_o      = bank[6][`TRC_B_DCSHIFT];
// Inverted sense: zero forces soft blend on, as the immunity setup needs.
assign forced_soft_blend_n_o = bank[6][`TRC_B_FBLEND_N];

////////////////////////////////////////////////////////////////////////////////
// Band and power settings.

assign band_range_select_o = bank[7][`TRC_B_RANGE];
// Clear allows 350 kHz for FM, set caps at 150 kHz for AM.
assign if_osc_limit_o      = bank[7][`TRC_B_IFLIM];
assign if_gain_speed_n_o   = bank[7][`TRC_B_IFSPD_N];
// Clear is FM, set is AM. The settle wait after moving to AM is the
// host's job; nothing here times it.
assign band_select_o       = bank[7][`TRC_B_BAND];
assign audio_amp_enable_o  = bank[7][`TRC_B_AMP];
assign audio_mute_n_o      = bank[7][`TRC_B_UNMUTE];
assign am_antenna_cal_o    = bank[7][`TRC_B_AMCAL];
assign radio_power_o       = bank[7][`TRC_B_PWR];

// Power save is the registered inverse of the power bit, so the analog side
// gets a clean level; the bank itself stays readable in power save.
always @(posedge ref_clk_i)
begin
    if (srst_i)
    begin
        power_save_o <= 1'b1;
    end
    else if (ce_i)
    begin
        power_save_o <= ~bank[7][`TRC_B_PWR];
    end
end

endmodule
`default_nettype wire

// ### verif/trc_radio_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "trc_map.vh"

// Watches some of the bank outputs, power save and the data pin of the control block.
module trc_radio_ctrl_checker
(
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       ce_i,
    input wire logic       chip_enable_i,
    input wire logic       serial_out_o,
    input wire logic       serial_out_oe_o,
    input wire logic       iq_phase_swap_o,
    input wire logic       if_sign_select_o,
    input wire logic [1:0] rf_osc_level_o,
    input wire logic       deemphasis_select_o,
    input wire logic [1:0] volume_level_o,
    input wire logic       am_highcut_enable_o,
    input wire logic [2:0] am_antenna_gain_o,
    input wire logic [2:0] am_detect_level_o,
    input wire logic [1:0] am_gain_loop_speed_o,
    input wire logic       band_range_select_o,
    input wire logic       if_osc_limit_o,
    input wire logic       band_select_o,
    input wire logic       radio_power_o,
    input wire logic       rf_gain_loop_enable_o,
    input wire logic       power_save_o
);
    logic [1:0] quiet;
    wire logic [7:0] mixer = {iq_phase_swap_o, if_sign_select_o, rf_osc_level_o, deemphasis_select_o,
                              volume_level_o, am_highcut_enable_o};

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    // Counts cycles with the frame closed; a write lands two cycles after its last bit, so three is safe.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || (ce_i && chip_enable_i))
            quiet <= 2'h0;
        else if (ce_i && quiet != 2'h3)
            quiet <= quiet + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    mixer_hold_a: assert property (quiet == 2'h3 |-> $stable(mixer))
        else $error("mixer fields changed outside a frame");
    amosc_hold_a: assert property (quiet == 2'h3 |-> $stable({am_antenna_gain_o, am_detect_level_o,
        am_gain_loop_speed_o})) else $error("antenna fields changed outside a frame");
    band_hold_a: assert property ((quiet == 2'h3) [*2] |-> $stable({band_range_select_o,
        if_osc_limit_o, band_select_o, radio_power_o})) else $error("band fields changed outside a frame");
    power_save_a: assert property (!$past(srst_i) && $past(ce_i) |-> power_save_o == !$past(radio_power_o))
        else $error("power save does not follow radio power");
    power_up_a: assert property ($rose(radio_power_o) && ce_i |=> $fell(power_save_o))
        else $error("power save did not leave on power up");
    data_release_a: assert property (quiet == 2'h3 |-> !serial_out_oe_o)
        else $error("data pin held low outside a frame");
    od_low_a: assert property (serial_out_o == 1'b0)
        else $error("open drain level is not low");
    reset_levels_a: assert property (disable iff (1'b0) srst_i && ce_i |=> power_save_o &&
        !serial_out_oe_o && mixer == `TRC_RST_MIXER && rf_gain_loop_enable_o) else $error("bad reset levels");
endmodule

bind trc_radio_ctrl trc_radio_ctrl_checker u_trc_radio_ctrl_checker
(
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .chip_enable_i(chip_enable_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .iq_phase_swap_o(iq_phase_swap_o),
    .if_sign_select_o(if_sign_select_o), .rf_osc_level_o(rf_osc_level_o), .deemphasis_select_o(deemphasis_select_o),
    .volume_level_o(volume_level_o), .am_highcut_enable_o(am_highcut_enable_o), .am_antenna_gain_o(am_antenna_gain_o),
    .am_detect_level_o(am_detect_level_o), .am_gain_loop_speed_o(am_gain_loop_speed_o),
    .band_range_select_o(band_range_select_o), .if_osc_limit_o(if_osc_limit_o), .band_select_o(band_select_o),
    .radio_power_o(radio_power_o), .rf_gain_loop_enable_o(rf_gain_loop_enable_o), .power_save_o(power_save_o)
);

`default_nettype wire

// ### verif/trc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the three-wire control bus; its clock rests low outside frames.
module trc_host_model
#(
    parameter int AM_SETTLE = 16  // Shortened stand-in for the long settle after an AM switch.
)
(
    input  wire logic ref_clk_i,
    input  wire logic serial_data_i,
    output var  logic chip_enable_o,
    output var  logic serial_clock_o,
    output var  logic serial_in_o
);
    localparam int HALF = 3;  // Three cycles a phase keeps clear of the two-cycle minimum.

    // Idle levels at time zero.
    initial
    begin
        chip_enable_o  = 1'b0;
        serial_clock_o = 1'b0;
        serial_in_o    = 1'b0;
    end

    // Steps just past the edge so changes never race the sampling edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Sends n bits lowest first, each set up while the clock is low.
    task automatic send_bits(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_clock_o = 1'b0;
            serial_in_o    = v[i];
            tick(HALF);
            serial_clock_o = 1'b1;
            tick(HALF);
        end
    endtask

    task automatic open_frame(input logic rd, input logic [6:0] ofs);
        chip_enable_o = 1'b1;
        tick(1);
        send_bits({8'h00, rd, ofs}, 8);
    endtask

    // The data line is flipped on close so a stale bit cannot pass for a valid one.
    task automatic close_frame();
        serial_clock_o = 1'b0;
        tick(HALF);
        chip_enable_o = 1'b0;
        serial_in_o   = ~serial_in_o;
        tick(2);
    endtask

    task automatic write_frame(input logic [6:0] ofs, input logic [15:0] data, input int nbits);
        logic [15:0] v;
        v = (ofs == 7'h19) ? ((data & 16'h2f2f) | 16'h4040) : data;
        open_frame(1'b0, ofs);
        send_bits(v, nbits);
        close_frame();
    endtask

    // Reads one byte, taking each bit just before the rising clock.
    task automatic read_reg(input logic [6:0] ofs, output logic [7:0] v);
        open_frame(1'b1, ofs);
        for (int i = 0; i < 8; i++)
        begin
            serial_clock_o = 1'b0;
            serial_in_o    = ~serial_in_o;
            tick(HALF);
            v[i] = serial_data_i;
            serial_clock_o = 1'b1;
            tick(HALF);
        end
        close_frame();
    endtask

    task automatic am_settle();
        tick(AM_SETTLE);
    endtask
endmodule

`default_nettype wire

// ### verif/tuner_radio_control_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "trc_map.vh"

module tuner_radio_control_registers_test;
    logic            ref_clk_i = 1'b0;
    logic            srst_i    = 1'b1;
    logic            ce        = 1'b1;
    int              bad_count = 0;
    int              compares  = 0;
    logic [7:0]      got;
    wire logic       chip_enable, serial_clock, serial_in, serial_out, serial_out_oe, power_save;
    wire logic       data_line;
    wire logic [7:0] f18, f19, f1a, f1c, f1d, f1e, f1f;

    localparam logic [6:0] OFS [8] = '{`TRC_OFS_MIXER, `TRC_OFS_AGC, `TRC_OFS_AMOSC, `TRC_OFS_HOLE,
                                       `TRC_OFS_STEREO, `TRC_OFS_STAUX, `TRC_OFS_BLEND, `TRC_OFS_BAND};
    localparam logic [7:0] RST [8] = '{`TRC_RST_MIXER, `TRC_RST_AGC, `TRC_RST_AMOSC, 8'h00,
                                       `TRC_RST_STEREO, `TRC_RST_STAUX, `TRC_RST_BLEND, `TRC_RST_BAND};
    localparam logic [7:0] MASK [8] = '{8'hff, 8'h2f, 8'hff, 8'h00, 8'hf7, 8'h13, 8'hff, 8'hff};
    // Patterns for the gain register keep its reserved bits fixed.
    localparam logic [7:0] PAT_A [8] = '{8'h5a, 8'h6b, 8'hc9, 8'h3c, 8'h96, 8'h13, 8'h71, 8'he8};
    localparam logic [7:0] PAT_B [8] = '{8'ha5, 8'h44, 8'h36, 8'hc3, 8'h69, 8'hec, 8'h8e, 8'h17};

`define TB_CHECK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end

    // 125 MHz clock; the data pin has a pull-up.
    always #4 ref_clk_i = ~ref_clk_i;
    assign data_line = serial_out_oe ? serial_out : 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    trc_host_model u_host (.ref_clk_i(ref_clk_i), .serial_data_i(data_line), .chip_enable_o(chip_enable),
        .serial_clock_o(serial_clock), .serial_in_o(serial_in));

    trc_radio_ctrl u_trc_radio_ctrl
    (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce), .chip_enable_i(chip_enable),
        .serial_clock_i(serial_clock), .serial_in_i(serial_in), .serial_out_o(serial_out),
        .serial_out_oe_o(serial_out_oe), .iq_phase_swap_o(f18[7]), .if_sign_select_o(f18[6]),
        .rf_osc_level_o(f18[5:4]), .deemphasis_select_o(f18[3]), .volume_level_o(f18[2:1]),
        .am_highcut_enable_o(f18[0]), .am_mute_enable_o(f19[5]), .if_gain_speed_o(f19[3]),
        .rf_gain_speed_o(f19[2:1]), .rf_gain_loop_enable_o(f19[0]), .am_antenna_gain_o(f1a[7:5]),
        .am_detect_level_o(f1a[4:2]), .am_gain_loop_speed_o(f1a[1:0]), .capture_range_o(f1c[7:6]),
        .stereo_fast_sense_o(f1c[5]), .stereo_slow_sense_o(f1c[4]), .pilot_cancel_enable_o(f1c[2]),
        .forced_stereo_o(f1c[1]), .stereo_mono_select_o(f1c[0]), .forced_gain_loop_o(f1d[4]),
        .separation_trim_o(f1d[1:0]), .soft_blend_level_o(f1e[7:5]), .soft_mute_level_o(f1e[4:2]),
        .audio_dc_shift_o(f1e[1]), .forced_soft_blend_n_o(f1e[0]), .band_range_select_o(f1f[7]),
        .if_osc_limit_o(f1f[6]), .if_gain_speed_n_o(f1f[5]), .band_select_o(f1f[4]),
        .audio_amp_enable_o(f1f[3]), .audio_mute_n_o(f1f[2]), .am_antenna_cal_o(f1f[1]),
        .radio_power_o(f1f[0]), .power_save_o(power_save)
    );

    // Field outputs of one register, with bits that have no output masked off.
    function automatic logic [7:0] fields(input int i);
        case (i)
            0: return f18;
            1: return f19 & MASK[1];
            2: return f1a;
            4: return f1c & MASK[4];
            5: return f1d & MASK[5];
            6: return f1e;
            7: return f1f;
            default: return 8'h00;
        endcase
    endfunction

    // Reads a register back and compares its field outputs; the hole always reads zero.
    task automatic check_reg(input int i, input logic [7:0] v);
        logic [7:0] exp;
        exp = (i == 3) ? 8'h00 : v;
        u_host.read_reg(OFS[i], got);
        `TB_CHECK(got, exp)
        `TB_CHECK(fields(i) & 8'hf0, exp & MASK[i] & 8'hf0)
        `TB_CHECK(fields(i) & 8'h0f, exp & MASK[i] & 8'h0f)
        if (i == 7)
            `TB_CHECK(power_save, ~v[0])
    endtask

    task automatic finish_test();
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, two complementary patterns, writes off the map, then a mid-run reset.
    initial
    begin
        u_host.tick(5);
        srst_i = 1'b0;
        for (int i = 0; i < 8; i++)
            check_reg(i, RST[i]);
        for (int i = 0; i < 8; i++)
            u_host.write_frame(OFS[i], {8'h00, PAT_A[i]}, 8);
        u_host.write_frame(7'h20, 16'h00ff, 8);
        for (int i = 0; i < 8; i++)
            check_reg(i, PAT_A[i]);
        u_host.read_reg(7'h20, got);
        `TB_CHECK(got, 8'h00)
        for (int i = 0; i < 8; i++)
        begin
            u_host.write_frame(OFS[i], {8'h00, PAT_B[i]}, 8);
            check_reg(i, PAT_B[i]);
        end
        u_host.am_settle();
        // A second byte in one frame lands on the same offset; a short byte is dropped.
        u_host.write_frame(`TRC_OFS_BLEND, 16'h2d9c, 16);
        u_host.write_frame(`TRC_OFS_BLEND, 16'h00e0, 5);
        check_reg(6, 8'h2d);
        srst_i = 1'b1;
        u_host.tick(2);
        srst_i = 1'b0;
        for (int i = 0; i < 8; i++)
            check_reg(i, RST[i]);
        // With the enable low the whole block is frozen, so a full frame must leave no trace.
        ce = 1'b0;
        u_host.write_frame(`TRC_OFS_MIXER, 16'h00a5, 8);
        ce = 1'b1;
        check_reg(0, `TRC_RST_MIXER);
        finish_test();
    end

    // Cuts a hang short.
    initial
    begin
        repeat (40000) @(posedge ref_clk_i);
        bad_count++;
        finish_test();
    end
endmodule

`default_nettype wire
